// ### bench/scrc_board.sv
module scrc_board (
  input logic oe_i, drv_n_i, pull_low_i,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  assign pin_o = oe_i ? drv_n_i : !pull_low_i;
endmodule // scrc_board

// ### bench/scrc_top_props.sv
module scrc_top_props (
  input logic sys_clk_i, rst_n_i, sw_reset_i, pmc_wr_i,
  input logic running_reset_control_i, core_reset_n_o, core_start_o,
  input logic reset_output_n_o, reset_output_oe_o,
  input logic [6:0] pmc_mult_i, pll_mult_o,
  input logic [1:0] pmc_div_i, pll_div_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_start_pulse: assert property (core_start_o |=> !core_start_o)
    else $error("start pulse too long");
  chk_start_edge: assert property ($rose(core_reset_n_o) |-> core_start_o)
    else $error("core left reset without start");
  chk_sw_wait: assert property (sw_reset_i |=> !core_reset_n_o [*8])
    else $error("no lock wait after software reset");
  chk_pmc_write: assert property (pmc_wr_i && core_reset_n_o && !sw_reset_i
    |=> {pll_mult_o, pll_div_o} == $past({pmc_mult_i, pmc_div_i}))
    else $error("pll write lost");
  chk_pin_mode: assert property (running_reset_control_i && core_reset_n_o
    && !sw_reset_i |=> !reset_output_oe_o)
    else $error("pin still driven");
  chk_out_follow: assert property (reset_output_oe_o
    |-> reset_output_n_o == core_reset_n_o)
    else $error("reset output wrong");
  cover property (core_start_o);
  cover property (pmc_wr_i && core_reset_n_o);
  cover property (!core_reset_n_o && !reset_output_oe_o);
endmodule // scrc_top_props

bind scrc_top scrc_top_props scrc_top_props_i (.*);

// ### bench/scrc_top_tb.sv
module scrc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD %0t %h %h", $time, a, b); end end
  logic sys_clk_i = 0, rst_n_i = 0, sw_reset_i = 0, pmc_wr_i = 0, ctl = 0;
  logic pull = 0, pin, rout_n, oe, core_n, start, rsv;
  logic [1:0] cfg = 0, pmc_div_i = 0, div;
  logic [2:0] boot = 0, boot_o;
  logic [6:0] pmc_mult_i = 0, mult;
  int fail_count = 0, tests_run = 0, n;
  always #20 sys_clk_i = ~sys_clk_i;
  scrc_top scrc_top_i (.sys_clk_i, .rst_n_i, .clk_cfg_i(cfg),
    .boot_cfg_i(boot), .sw_reset_i, .pmc_wr_i, .pmc_mult_i, .pmc_div_i,
    .running_reset_control_i(ctl), .running_reset_input_n_i(pin),
    .reset_output_n_o(rout_n), .reset_output_oe_o(oe),
    .core_reset_n_o(core_n), .core_start_o(start), .pll_mult_o(mult),
    .pll_div_o(div), .clk_cfg_rsv_o(rsv), .boot_cfg_o(boot_o));
  scrc_board scrc_board_i (.oe_i(oe), .drv_n_i(rout_n), .pull_low_i(pull),
    .pin_o(pin));
  task automatic results;
    if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wait_start;
    n = 0;
    do begin tick(1); n++; end while (start !== 1'b1 && n < 5000);
    if (n >= 5000) begin fail_count++; results(); end
  endtask
  function automatic logic [6:0] ratio(logic [1:0] c);
    return c == 2'h1 ? 7'h20 : c == 2'h2 ? 7'h10 : 7'h08;
  endfunction
  initial begin
    void'($urandom(32'hb73b));
    tick(16); rst_n_i = 1;
    wait_start;
    for (int c = 0; c < 4; c++) begin
      cfg = 2'(c); boot = 3'($urandom); tick(4);
      sw_reset_i = 1; tick(1); sw_reset_i = 0; pmc_wr_i = 1; tick(1);
      pmc_wr_i = 0;
      `CHK({core_n, rout_n}, 2'b00)
      wait_start;
      `CHK(n, 4095)
      `CHK({core_n, rout_n}, 2'b11)
      `CHK(mult, ratio(cfg))
      `CHK(rsv, c == 3)
      `CHK(boot_o, boot)
      pmc_mult_i = 7'($urandom); pmc_div_i = 2'($urandom); pmc_wr_i = 1;
      tick(1); pmc_wr_i = 0;
      `CHK({mult, div}, {pmc_mult_i, pmc_div_i})
    end
    ctl = 1; tick(2);
    `CHK(oe, 1'b0)
    pull = 1; tick(4);
    `CHK(core_n, 1'b0)
    pull = 0; wait_start;
    `CHK(core_n, 1'b1)
    sw_reset_i = 1; tick(1); sw_reset_i = 0;
    `CHK(oe, 1'b1)
    wait_start; tick(4);
    `CHK(core_n, 1'b1)
    ctl = 0; tick(2);
    `CHK(oe, 1'b1)
    rst_n_i = 0; tick(2);
    `CHK({core_n, rout_n, oe}, 3'b001)
    rst_n_i = 1; wait_start;
    `CHK(n, 4096)
    results();
  end
endmodule // scrc_top_tb

// ### logic/scrc_map.vh
`ifndef SCRC_MAP_VH
`define SCRC_MAP_VH

// Lock wait after the reset pin is released, in input clock cycles.
`define SCRC_LOCK_CYCLES 13'h1000
`define SCRC_LOCK_LAST 13'h0FFF
`define SCRC_CNT_ZERO 13'h0000
`define SCRC_CNT_ONE 13'h0001

// Clock ratio pin codes.
`define SCRC_CFG_8 2'h0
`define SCRC_CFG_32 2'h1
`define SCRC_CFG_16 2'h2
`define SCRC_CFG_RSV 2'h3

// Start-up multiplier values for each ratio.
`define SCRC_MULT_8 7'h08
`define SCRC_MULT_32 7'h20
`define SCRC_MULT_16 7'h10
`define SCRC_MULT_RST 7'h08

// Divider, boot and clock config reset values.
`define SCRC_DIV_RST 2'h0
`define SCRC_BOOT_RST 3'h0
`define SCRC_CFG_RST 2'h0

// Pin release history reset value and the stage that marks it trusted.
`define SCRC_REL_RST 2'h0
`define SCRC_REL_LAST 1

// One-hot sequencer states.
`define SCRC_ST_LOCK 3'h1
`define SCRC_ST_RUN 3'h2
`define SCRC_ST_RRST 3'h4

`endif

// ### logic/scrc_sync.v
module scrc_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset.
  input wire sys_clk_i,
  input wire rst_n_i,
  // Asynchronous level in, synchronised level out.
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule // scrc_sync

// ### logic/scrc_top.v
`include "scrc_map.vh"

module scrc_top (
  // Clock and hardware reset.
  input wire sys_clk_i,
  input wire rst_n_i,
  // Configuration pins.
  input wire [1:0] clk_cfg_i,
  input wire [2:0] boot_cfg_i,
  // Software reset request from the core.
  input wire sw_reset_i,
  // Power management control write port.
  input wire pmc_wr_i,
  input wire [6:0] pmc_mult_i,
  input wire [1:0] pmc_div_i,
  // Running reset control bit 0.
  input wire running_reset_control_i,
  // Shared reset pin.
  input wire running_reset_input_n_i,
  output reg reset_output_n_o,
  output reg reset_output_oe_o,
  // Core side.
  output reg core_reset_n_o,
  output reg core_start_o,
  output reg [6:0] pll_mult_o,
  output reg [1:0] pll_div_o,
  output reg clk_cfg_rsv_o,
  output reg [2:0] boot_cfg_o
);

  localparam ST_LOCK = `SCRC_ST_LOCK;
  localparam ST_RUN = `SCRC_ST_RUN;
  localparam ST_RRST = `SCRC_ST_RRST;

  wire [1:0] clk_cfg_s;
  wire [2:0] boot_cfg_s;
  wire rr_in_n_s;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [12:0] cnt_q;
  reg [12:0] cnt_d;
  reg rr_en_q;
  reg [1:0] rel_q;

  // Maps the ratio pins onto a start-up multiplier.
  function [6:0] ratio_mult;
    input [1:0] cfg;
    begin
      case (cfg)
        `SCRC_CFG_8: ratio_mult = `SCRC_MULT_8;
        `SCRC_CFG_32: ratio_mult = `SCRC_MULT_32;
        `SCRC_CFG_16: ratio_mult = `SCRC_MULT_16;
        default: ratio_mult = `SCRC_MULT_RST;
      endcase
    end
  endfunction

  // Decodes the running state of a state code.
  function is_run;
    input [2:0] st;
    begin
      is_run = (st == ST_RUN);
    end
  endfunction

  // Decodes the lock wait state of a state code.
  function is_lock;
    input [2:0] st;
    begin
      is_lock = (st == ST_LOCK);
    end
  endfunction

  // Pins are synchronised before use.
  scrc_sync #(.WIDTH(6), .RST_VAL(6'h01)) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({boot_cfg_i, clk_cfg_i, running_reset_input_n_i}),
    .sync_o({boot_cfg_s, clk_cfg_s, rr_in_n_s})
  );

  // Sequencer next state.
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_LOCK: begin
        cnt_d = cnt_q + `SCRC_CNT_ONE;
        if (cnt_q == `SCRC_LOCK_LAST) begin
          state_d = ST_RUN;
          cnt_d = `SCRC_CNT_ZERO;
        end
      end
      ST_RUN: begin
        cnt_d = `SCRC_CNT_ZERO;
        if (rr_en_q && rel_q[`SCRC_REL_LAST] && !rr_in_n_s) begin
          state_d = ST_RRST;
        end
      end
      ST_RRST: begin
        cnt_d = `SCRC_CNT_ZERO;
        if (!rr_en_q || rr_in_n_s) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_LOCK;
        cnt_d = `SCRC_CNT_ZERO;
      end
    endcase
    // Software reset restarts the lock wait.
    if (sw_reset_i) begin
      state_d = ST_LOCK;
      cnt_d = `SCRC_CNT_ZERO;
    end
  end

  // Sequencer state and lock counter.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_LOCK;
      cnt_q <= `SCRC_CNT_ZERO;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Control bit and a record of how long the pin has been released.
  // The synchroniser still holds the driven level for two cycles after
  // the pin is let go, so the pin is not trusted before then.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rr_en_q <= 1'b0;
      rel_q <= `SCRC_REL_RST;
    end else begin
      rr_en_q <= running_reset_control_i;
      rel_q <= {rel_q[0], !reset_output_oe_o};
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_reset_n_o <= 1'b0;
    end else begin
      core_reset_n_o <= is_run(state_d);
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_start_o <= 1'b0;
    end else begin
      core_start_o <= is_run(state_d) && !is_run(state_q);
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_output_n_o <= 1'b0;
    end else begin
      reset_output_n_o <= is_run(state_d);
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_output_oe_o <= 1'b1;
    end else begin
      reset_output_oe_o <= !running_reset_control_i || is_lock(state_d);
    end
  end

  // Multiplier follows the ratio pins and divider holds its reset value until the core runs.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pll_mult_o <= `SCRC_MULT_RST;
      pll_div_o <= `SCRC_DIV_RST;
    end else if (is_lock(state_q)) begin
      pll_mult_o <= ratio_mult(clk_cfg_s);
      pll_div_o <= `SCRC_DIV_RST;
    end else if (pmc_wr_i) begin
      pll_mult_o <= pmc_mult_i;
      pll_div_o <= pmc_div_i;
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_cfg_rsv_o <= 1'b0;
    end else if (is_lock(state_q)) begin
      clk_cfg_rsv_o <= (clk_cfg_s == `SCRC_CFG_RSV);
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_cfg_o <= `SCRC_BOOT_RST;
    end else if (is_lock(state_q)) begin
      boot_cfg_o <= boot_cfg_s;
    end
  end

endmodule // scrc_top
